// *** design/sfr_pkg.sv ***
package sfr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry and address fields
  localparam int          PAGE_W    = 11;
  localparam int          BYTE_W    = 9;
  localparam int          ADDR_W    = PAGE_W + BYTE_W;
  localparam int          PAGE_MSB  = 19;
  localparam int          PAGE_LSB  = 9;
  localparam int          BYTE_MSB  = 8;
  localparam logic [10:0] LAST_PAGE = 11'h7ff;
  localparam logic [8:0]  LAST_BYTE = 9'h107;
  localparam logic [3:0]  RSV_BITS  = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes and header bit positions
  localparam logic [7:0]  OP_READ_POL   = 8'h68;
  localparam logic [7:0]  OP_READ_SPI   = 8'he8;
  localparam logic [6:0]  HDR_OPC_LAST  = 7'h07;
  localparam logic [6:0]  HDR_ADDR_LAST = 7'h1f;
  localparam logic [6:0]  HDR_LAST      = 7'h3f;
  localparam logic [6:0]  HDR_BITS      = 7'h40;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int SYS_PERIOD_NS           = 20;
  localparam int SCK_HALF_NS             = 80;
  localparam int SCK_HALF_CYC            =
    (SCK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int BURST_BOUNDARY_DELAY_NS = 100;
  localparam int BRBD_CYC                =
    (BURST_BOUNDARY_DELAY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [PAGE_W-1:0] sfr_page_t;
  typedef logic [BYTE_W-1:0] sfr_byte_t;

  typedef enum logic [2:0]
  {
    HST_IDLE,
    HST_SETUP,
    HST_SHIFT,
    HST_BOUND,
    HST_HOLD
  } sfr_hst_e;

  ////////////////////////////////////////////////////////////////////////////
  // Byte position helpers
  function automatic logic at_page_end(sfr_byte_t b);
    return b >= LAST_BYTE;
  endfunction

  function automatic sfr_byte_t byte_step(sfr_byte_t b);
    return at_page_end(b) ? 9'h000 : b + 9'h001;
  endfunction

endpackage

// *** design/sfr_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface sfr_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;

  modport dev
  (
    input  cs_n,
    input  sck,
    input  si,
    output so,
    output so_oe
  );

  modport host
  (
    output cs_n,
    output sck,
    output si,
    input  so,
    input  so_oe
  );
endinterface

`default_nettype wire

// *** design/sfr_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Select fall, 8-bit opcode, then address
// - Host clocks SI only while selected
// - All fields shift MSB first
// - Buffer byte address is 9 bits
// - Four read clock modes, opcode picks category
// - Read opcode 68H/E8H, 24 address, 32 dummy
// - Top four address bits are reserved
// - Then 11 page bits, 9 byte bits
// - Data only after the 32 dummy bits
// - Address counter advances every byte
// - Host keeps select low whole read
// - Page end flows into next page
// - Array end wraps to page zero
// - Select rise ends read, output floats
// - Array read bypasses both page buffers
// - Burst read shares continuous read sequence
// - Programming self-timed, no prior erase
// - Program by page, erase page or block
// - 2048 pages of 264 bytes
// - Host waits boundary delay in bursts
module sfr_dev
  import sfr_pkg::*;
(
  input  wire logic              CLK_SYS,
  input  wire logic              RSTN,
  sfr_link_if.dev                LINK,
  output logic      [ADDR_W-1:0] ARR_ADDR,
  input  wire logic [7:0]        ARR_DATA,
  output logic                   READ_ACTIVE,
  output logic                   START_VALID,
  output logic      [PAGE_W-1:0] START_PAGE,
  output logic                   PAGE_CROSS,
  output logic                   ARRAY_WRAP
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain state

  logic        link_rst_n;
  logic [6:0]  hdr_reg;
  logic [30:0] sh_reg;
  logic        op_ok_reg;
  logic        spi_reg;
  logic        data_reg;
  sfr_page_t   page_reg;
  sfr_byte_t   byte_reg;
  logic [2:0]  bit_reg;
  logic        so_neg_reg;
  logic [2:0]  tgl_reg;
  logic [2:0]  tgl_next;
  sfr_page_t   start_page_reg;

  ////////////////////////////////////////////////////////////////////////////
  // System domain state

  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic [2:0]  sync3_reg;
  logic [2:0]  pulse_reg;
  sfr_page_t   start_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Deselect clears the whole frame at once, no clock needed
  assign link_rst_n = RSTN & ~LINK.cs_n;

  wire        in_hdr;
  wire        opc_last;
  wire        addr_last;
  wire        hdr_last;
  wire [7:0]  opc_word;
  wire [23:0] addr_word;
  wire        op_hit;
  wire        op_spi;
  wire        byte_end;
  wire        page_end;
  wire        array_end;
  wire        so_bit;

  assign in_hdr    = hdr_reg != HDR_BITS;
  assign opc_last  = hdr_reg == HDR_OPC_LAST;
  assign addr_last = hdr_reg == HDR_ADDR_LAST;
  assign hdr_last  = hdr_reg == HDR_LAST;
  assign opc_word  = {sh_reg[6:0], LINK.si};
  assign addr_word = {sh_reg[22:0], LINK.si};

  // Burst and continuous reads share both opcodes
  assign op_hit = (opc_word == OP_READ_POL) | (opc_word == OP_READ_SPI);
  assign op_spi = opc_word == OP_READ_SPI;

  assign byte_end  = bit_reg == 3'h7;
  assign page_end  = byte_end & at_page_end(byte_reg);
  assign array_end = page_end & (page_reg == LAST_PAGE);

  // Bit 7 of each byte leaves first
  assign so_bit = ARR_DATA[~bit_reg];

  ////////////////////////////////////////////////////////////////////////////
  // Header capture on rising SCK

  always_ff @(posedge LINK.sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      hdr_reg   <= 7'h00;
      sh_reg    <= 31'h0000_0000;
      op_ok_reg <= 1'b0;
      spi_reg   <= 1'b0;
      data_reg  <= 1'b0;
    end
    else
    begin
      if (in_hdr)
      begin
        hdr_reg <= hdr_reg + 7'h01;
      end
      sh_reg <= {sh_reg[29:0], LINK.si};
      if (opc_last)
      begin
        op_ok_reg <= op_hit;
        spi_reg   <= op_spi;
      end
      // Unknown opcodes never reach the data phase
      if (hdr_last)
      begin
        data_reg <= op_ok_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array address counter

  always_ff @(posedge LINK.sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      page_reg <= 11'h000;
      byte_reg <= 9'h000;
      bit_reg  <= 3'h0;
    end
    else if (addr_last)
    begin
      // Reserved top nibble of the address is dropped
      page_reg <= addr_word[PAGE_MSB:PAGE_LSB];
      byte_reg <= addr_word[BYTE_MSB:0];
      bit_reg  <= 3'h0;
    end
    else if (data_reg)
    begin
      bit_reg <= bit_reg + 3'h1;
      if (byte_end)
      begin
        byte_reg <= byte_step(byte_reg);
      end
      // Page and array wrap take the same edge, no gap
      if (page_end)
      begin
        page_reg <= page_reg + 11'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage

  // Mode 0/3 category changes data on the falling edge
  always_ff @(negedge LINK.sck or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      so_neg_reg <= 1'b0;
    end
    else
    begin
      so_neg_reg <= so_bit;
    end
  end

  // The idle level of SCK never matters here, so each category
  // covers both clock polarities
  assign LINK.so    = spi_reg ? so_neg_reg : so_bit;
  assign LINK.so_oe = data_reg & ~LINK.cs_n;

  // Read-only array port; page buffers and programming are elsewhere
  assign ARR_ADDR = {page_reg, byte_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Events toward the system clock

  // Toggles live on RSTN only; a reset on deselect would fake events
  assign tgl_next = tgl_reg ^ {hdr_last & op_ok_reg,
                               data_reg & page_end,
                               data_reg & array_end};

  always_ff @(posedge LINK.sck or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tgl_reg        <= 3'h0;
      start_page_reg <= 11'h000;
    end
    else
    begin
      tgl_reg <= tgl_next;
      if (hdr_last & op_ok_reg)
      begin
        start_page_reg <= page_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock side

  // Start page is loaded on the same edge as its toggle and held until the next header
  // end, so it is settled before the synchronised toggle lets it be sampled
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sync1_reg     <= 4'h0;
      sync2_reg     <= 4'h0;
      sync3_reg     <= 3'h0;
      pulse_reg     <= 3'h0;
      start_out_reg <= 11'h000;
    end
    else
    begin
      sync1_reg <= {data_reg, tgl_reg};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg[2:0];
      pulse_reg <= sync2_reg[2:0] ^ sync3_reg;
      if (sync2_reg[2] ^ sync3_reg[2])
      begin
        start_out_reg <= start_page_reg;
      end
    end
  end

  assign READ_ACTIVE = sync2_reg[3];
  assign START_VALID = pulse_reg[2];
  assign PAGE_CROSS  = pulse_reg[1];
  assign ARRAY_WRAP  = pulse_reg[0];
  assign START_PAGE  = start_out_reg;

endmodule

`default_nettype wire

// *** design/sfr_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfr_host
  import sfr_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  sfr_link_if.host         LINK,
  input  wire logic        START,
  input  wire logic        CATEGORY_SPI,
  input  wire logic        IDLE_HIGH,
  input  wire logic        BURST,
  input  wire sfr_page_t   PAGE,
  input  wire sfr_byte_t   BYTE,
  input  wire logic [15:0] LEN,
  output logic             BUSY,
  output logic             RX_VALID,
  output logic       [7:0] RX_DATA,
  output logic             DONE
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  sfr_hst_e    st_reg;
  sfr_hst_e    st_next;
  logic [7:0]  tick_reg;
  logic [7:0]  tick_next;
  logic        sck_reg;
  logic        sck_next;
  logic        cs_n_reg;
  logic        cs_n_next;
  logic [31:0] tx_reg;
  logic [31:0] tx_next;
  logic [6:0]  rise_reg;
  logic [6:0]  rise_next;
  logic [7:0]  rx_reg;
  logic [7:0]  rx_next;
  logic [7:0]  data_reg;
  logic [7:0]  data_next;
  logic [2:0]  nbit_reg;
  logic [2:0]  nbit_next;
  logic [15:0] left_reg;
  logic [15:0] left_next;
  sfr_byte_t   pos_reg;
  sfr_byte_t   pos_next;
  logic [2:0]  cfg_reg;
  logic [2:0]  cfg_next;
  logic        vld_reg;
  logic        vld_next;
  logic        done_reg;
  logic        done_next;
  logic        so_s1_reg;
  logic        so_s2_reg;
  logic        sample;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire tick_end;
  wire bnd_end;
  wire hdr_done;
  wire finished;
  wire spi_cat;
  wire idle_lvl;
  wire burst;
  wire [7:0] opcode;

  assign tick_end = tick_reg == 8'(SCK_HALF_CYC - 1);
  assign bnd_end  = tick_reg == 8'(BRBD_CYC - 1);
  assign hdr_done = rise_reg == HDR_BITS;
  assign finished = hdr_done & (left_reg == 16'h0000);
  assign spi_cat  = cfg_reg[2];
  assign idle_lvl = cfg_reg[1];
  assign burst    = cfg_reg[0];
  assign opcode   = CATEGORY_SPI ? OP_READ_SPI : OP_READ_POL;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    st_next   = st_reg;
    tick_next = tick_reg + 8'h01;
    sck_next  = sck_reg;
    cs_n_next = cs_n_reg;
    tx_next   = tx_reg;
    rise_next = rise_reg;
    rx_next   = rx_reg;
    data_next = data_reg;
    nbit_next = nbit_reg;
    left_next = left_reg;
    pos_next  = pos_reg;
    cfg_next  = cfg_reg;
    vld_next  = 1'b0;
    done_next = 1'b0;
    sample    = 1'b0;
    case (st_reg)
      HST_IDLE:
      begin
        tick_next = 8'h00;
        sck_next  = IDLE_HIGH;
        if (START)
        begin
          st_next   = HST_SETUP;
          cs_n_next = 1'b0;
          tx_next   = {opcode, RSV_BITS, PAGE, BYTE};
          rise_next = 7'h00;
          nbit_next = 3'h0;
          left_next = LEN;
          pos_next  = BYTE;
          cfg_next  = {CATEGORY_SPI, IDLE_HIGH, BURST};
        end
      end
      HST_SETUP:
      begin
        if (tick_end)
        begin
          tick_next = 8'h00;
          st_next   = HST_SHIFT;
        end
      end
      HST_SHIFT:
      begin
        if (tick_end)
        begin
          tick_next = 8'h00;
          if (finished & (sck_reg == idle_lvl))
          begin
            st_next   = HST_HOLD;
            cs_n_next = 1'b1;
          end
          else
          begin
            // SCK only toggles while select is low
            sck_next = ~sck_reg;
            if (~sck_reg & ~hdr_done)
            begin
              rise_next = rise_reg + 7'h01;
            end
            // SI moves on falls, after the first rise
            if (sck_reg & (rise_reg != 7'h00))
            begin
              tx_next = {tx_reg[30:0], 1'b0};
            end
            sample = hdr_done & ~finished & (~sck_reg == spi_cat);
          end
        end
      end
      HST_BOUND:
      begin
        if (bnd_end)
        begin
          tick_next = 8'h00;
          st_next   = HST_SHIFT;
        end
      end
      HST_HOLD:
      begin
        if (tick_end)
        begin
          st_next   = HST_IDLE;
          done_next = 1'b1;
        end
      end
      default:
      begin
        st_next   = HST_IDLE;
        cs_n_next = 1'b1;
      end
    endcase
    if (sample)
    begin
      rx_next   = {rx_reg[6:0], so_s2_reg};
      nbit_next = nbit_reg + 3'h1;
      if (nbit_reg == 3'h7)
      begin
        data_next = {rx_reg[6:0], so_s2_reg};
        vld_next  = 1'b1;
        left_next = left_reg - 16'h0001;
        pos_next  = byte_step(pos_reg);
        // Hold off the next SCK pulse across a page or array boundary
        if (burst & at_page_end(pos_reg))
        begin
          st_next = HST_BOUND;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_reg   <= HST_IDLE;
      tick_reg <= 8'h00;
      sck_reg  <= 1'b0;
      cs_n_reg <= 1'b1;
      tx_reg   <= 32'h0000_0000;
      rise_reg <= 7'h00;
      rx_reg   <= 8'h00;
      data_reg <= 8'h00;
      nbit_reg <= 3'h0;
      left_reg <= 16'h0000;
      pos_reg  <= 9'h000;
      cfg_reg  <= 3'h0;
      vld_reg  <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      tick_reg <= tick_next;
      sck_reg  <= sck_next;
      cs_n_reg <= cs_n_next;
      tx_reg   <= tx_next;
      rise_reg <= rise_next;
      rx_reg   <= rx_next;
      data_reg <= data_next;
      nbit_reg <= nbit_next;
      left_reg <= left_next;
      pos_reg  <= pos_next;
      cfg_reg  <= cfg_next;
      vld_reg  <= vld_next;
      done_reg <= done_next;
    end
  end

  // SO settles a half period before use, so two stages cost nothing
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      so_s1_reg <= 1'b0;
      so_s2_reg <= 1'b0;
    end
    else
    begin
      so_s1_reg <= LINK.so;
      so_s2_reg <= so_s1_reg;
    end
  end

  assign LINK.cs_n = cs_n_reg;
  assign LINK.sck  = sck_reg;
  assign LINK.si   = tx_reg[31];
  assign BUSY      = st_reg != HST_IDLE;
  assign RX_VALID  = vld_reg;
  assign RX_DATA   = data_reg;
  assign DONE      = done_reg;

endmodule

`default_nettype wire

// *** tb/sfr_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfr_link_checker
  import sfr_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_oe
);
  logic        sck_reg;
  logic [15:0] cnt_reg;
  logic [7:0]  op_reg;
  wire         rise_w = sck & ~sck_reg;
  wire  [15:0] cnt_w  = cnt_reg + {15'h0000, rise_w};
  wire         op_ok  = op_reg == OP_READ_POL || op_reg == OP_READ_SPI;

  // Link is sampled 8x per serial clock, so no edge is missed
  always_ff @(posedge CLK_SYS or negedge RSTN)
    if (!RSTN)
    begin
      sck_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      op_reg  <= 8'h00;
    end
    else
    begin
      sck_reg <= sck;
      cnt_reg <= cs_n ? 16'h0000 : cnt_w;
      if (cs_n)
        op_reg <= 8'h00;
      else if (rise_w && cnt_reg < 16'h0008)
        op_reg <= {op_reg[6:0], si};
    end

  ////////////////////////////////////////
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  sequence s_quiet;
    $stable(sck) [*3];
  endsequence

  property p_oe_desel; cs_n |-> !so_oe; endproperty
  a_oe_desel: assert property (p_oe_desel)
    else $error("so_oe while deselected");
  property p_oe_hdr; !cs_n && cnt_w < 16'h0040 |-> !so_oe; endproperty
  a_oe_hdr: assert property (p_oe_hdr)
    else $error("so_oe in header");
  property p_oe_data; !cs_n && op_ok && cnt_w >= 16'h0040 |-> so_oe;
  endproperty
  a_oe_data: assert property (p_oe_data)
    else $error("so_oe missing in data");
  property p_oe_hold; so_oe |=> so_oe || cs_n; endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("so_oe dropped in frame");
  property p_opcode; !cs_n && cnt_reg == 16'h0008 |-> op_ok; endproperty
  a_opcode: assert property (p_opcode)
    else $error("bad opcode shifted");
  // 68H with an idle-low clock stops one rise short of a whole byte,
  // since its last bit is out after the rise and taken on the fall
  property p_end;
    $rose(cs_n) |-> cnt_reg == 16'h0040 ||
      (cnt_reg > 16'h0040 &&
       cnt_reg[2:0] == ((op_reg == OP_READ_POL && !sck) ? 3'h7 : 3'h0));
  endproperty
  a_end: assert property (p_end)
    else $error("frame ended early");
  property p_si_rise; !cs_n && rise_w |-> $stable(si); endproperty
  a_si_rise: assert property (p_si_rise)
    else $error("si moved at rise");
  property p_spacing; !cs_n && $changed(sck) |=> s_quiet; endproperty
  a_spacing: assert property (p_spacing)
    else $error("sck half period short");
  property p_setup; $fell(cs_n) |=> s_quiet; endproperty
  a_setup: assert property (p_setup)
    else $error("sck moved at select");
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("Error %0t: got %0h exp %0h", $time, (g), (e)); \
    end \
  end

module tb_top
  import sfr_pkg::*;
;
  logic        clk_sys, rstn, start, cat_spi, idle_hi, burst;
  sfr_page_t   page, st_page;
  sfr_byte_t   pg_byte;
  logic [15:0] len;
  logic        busy, rx_valid, done, rd_act, st_valid, pg_cross, a_wrap;
  logic [7:0]  rx_data, exp_b;
  logic [7:0]  exp_q[$];
  logic [19:0] arr_addr;
  int          num_errors, cmp_count, seed, n_rx, n_st, n_pc, n_aw;
  sfr_link_if  lk();
  sfr_link_if  lk2();

  // Array contents: mixes page and byte so a wrong address shows
  function automatic logic [7:0] arr_f(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {a[19:16], 4'h5};
  endfunction

  sfr_dev u_sfr_dev
  (
    .CLK_SYS(clk_sys), .RSTN(rstn), .LINK(lk), .ARR_ADDR(arr_addr),
    .ARR_DATA(arr_f(arr_addr)), .READ_ACTIVE(rd_act),
    .START_VALID(st_valid), .START_PAGE(st_page),
    .PAGE_CROSS(pg_cross), .ARRAY_WRAP(a_wrap)
  );
  // Second device faces a bench-driven link that breaks host rules
  sfr_dev u_sfr_dev_b
  (
    .CLK_SYS(clk_sys), .RSTN(rstn), .LINK(lk2), .ARR_ADDR(),
    .ARR_DATA(8'h00), .READ_ACTIVE(), .START_VALID(), .START_PAGE(),
    .PAGE_CROSS(), .ARRAY_WRAP()
  );
  sfr_host u_sfr_host
  (
    .CLK_SYS(clk_sys), .RSTN(rstn), .LINK(lk), .START(start),
    .CATEGORY_SPI(cat_spi), .IDLE_HIGH(idle_hi), .BURST(burst),
    .PAGE(page), .BYTE(pg_byte), .LEN(len), .BUSY(busy),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .DONE(done)
  );
  sfr_link_checker u_chk
  (
    .CLK_SYS(clk_sys), .RSTN(rstn), .cs_n(lk.cs_n), .sck(lk.sck),
    .si(lk.si), .so_oe(lk.so_oe)
  );

  ////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    #1_000_000;
    num_errors++;
    final_report();
  end

  always @(negedge clk_sys)
  begin
    n_st += st_valid;
    n_pc += pg_cross;
    n_aw += a_wrap;
    if (rx_valid)
    begin
      n_rx++;
      exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK(rx_data, exp_b)
    end
  end

  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic run(input logic c, h, b, input sfr_page_t p,
                     input sfr_byte_t y, input logic [15:0] n, input int ab);
    logic lw;
    int   xpc, xaw, k;
    cat_spi = c;
    idle_hi = h;
    burst = b;
    page = p;
    pg_byte = y;
    len = n;
    lw = 1'b0;
    xpc = 0;
    xaw = 0;
    // Reference stream: byte >= 263 ends its page
    for (k = 0; k < n; k++)
    begin
      exp_q.push_back(arr_f({p, y}));
      lw = y >= 9'h107;
      // Last byte's crossing is clocked unless 68H with idle-low clock
      if (lw && (k < n - 1 || c || h))
      begin
        xpc++;
        xaw += (p == 11'h7ff);
      end
      if (lw)
        p = p + 11'h001;
      y = lw ? 9'h000 : y + 9'h001;
    end
    repeat (3) @(negedge clk_sys);
    n_rx = 0;
    n_st = 0;
    n_pc = 0;
    n_aw = 0;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    `CHK(lk.cs_n, 1'b0)
    repeat (20) @(negedge clk_sys);
    page = ~page;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    page = ~page;
    if (ab > 0)
    begin
      repeat (ab) @(negedge clk_sys);
      `CHK(rd_act, 1'b1)
      rstn = 1'b0;
      @(negedge clk_sys);
      `CHK(lk.so_oe, 1'b0)
      `CHK(busy, 1'b0)
      exp_q.delete();
      // Two edges in reset so the sync chains are cleared
      @(negedge clk_sys);
      rstn = 1'b1;
      return;
    end
    for (k = 0; k < 40000 && done !== 1'b1; k++)
      @(negedge clk_sys);
    `CHK(done, 1'b1)
    repeat (12) @(negedge clk_sys);
    `CHK(n_rx, int'(n))
    `CHK(n_st, 1)
    `CHK(st_page, page)
    `CHK(n_pc, xpc)
    `CHK(n_aw, xaw)
  endtask

  // Bench link: 64 ns clock, still while deselected
  task automatic frame2(input logic [7:0] op, input int nb, input logic oe);
    int i;
    #192;
    #11 lk2.cs_n = 1'b0;
    for (i = 0; i < nb; i++)
    begin
      lk2.si = (i < 8) ? op[7 - i] : 1'b0;
      #16 lk2.sck = 1'b1;
      #32 lk2.sck = 1'b0;
      #16;
    end
    `CHK(lk2.so_oe, oe)
    lk2.cs_n = 1'b1;
    lk2.si = 1'b1;
    #5 `CHK(lk2.so_oe, 1'b0)
  endtask

  ////////////////////////////////////////
  initial
  begin
    seed = 32'h0000_2dc7;
    num_errors = 0;
    cmp_count = 0;
    rstn = 1'b0;
    start = 1'b0;
    cat_spi = 1'b0;
    idle_hi = 1'b0;
    burst = 1'b0;
    page = 11'h000;
    pg_byte = 9'h000;
    len = 16'h0000;
    lk2.cs_n = 1'b1;
    lk2.sck = 1'b0;
    lk2.si = 1'b0;
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    // All four clock modes, continuous and burst
    for (int i = 0; i < 8; i++)
      run(i[0], i[1], i[2], 11'($random(seed)), 9'($random(seed)),
          16'(2 + i), 0);
    run(1'b1, 1'b0, 1'b1, 11'h0a5, 9'h106, 16'h0004, 0);
    run(1'b0, 1'b1, 1'b0, 11'h0a5, 9'h106, 16'h0004, 0);
    run(1'b1, 1'b1, 1'b1, 11'h7ff, 9'h105, 16'h0005, 0);
    run(1'b0, 1'b0, 1'b0, 11'h123, 9'h1ff, 16'h0003, 0);
    run(1'b1, 1'b0, 1'b0, 11'h001, 9'h000, 16'h0000, 0);
    run(1'b0, 1'b1, 1'b1, 11'h055, 9'h000, 16'h0010, 800);
    run(1'b1, 1'b0, 1'b0, 11'h056, 9'h107, 16'h0002, 0);
    frame2(8'h52, 72, 1'b0);
    frame2(OP_READ_SPI, 70, 1'b1);
    final_report();
  end
endmodule

`default_nettype wire
